/* File: dv/dabp_top_test.sv */
// Self-checking testbench for the converter readback and bypass block.
`timescale 1ns/1ns
`default_nettype none
module dabp_top_test;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic conv_valid = 1'b0;
    logic [2:0] conv_channel = 3'h0;
    logic [11:0] conv_raw = 12'h000;
    logic offset_valid = 1'b0;
    logic [11:0] offset_measured = 12'h000;
    logic [15:0] dac_code = 16'h0000;
    logic [11:0] thr_high = 12'h000;
    logic [11:0] thr_low = 12'h000;
    logic ground_sample_disable;
    logic irq;
    int bad_count = 0;
    int n_tests = 0;
    logic [15:0] flags_exp = 16'h0000;
    logic [5:0] idx_list [11] = '{6'h23, 6'h24, 6'h25, 6'h26, 6'h27, 6'h28,
        6'h2c, 6'h2d, 6'h2e, 6'h30, 6'h31};

    dabp_top uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .conv_valid(conv_valid),
        .conv_channel(conv_channel), .conv_raw(conv_raw),
        .offset_valid(offset_valid), .offset_measured(offset_measured),
        .dac_code(dac_code), .thr_high(thr_high), .thr_low(thr_low),
        .ground_sample_disable(ground_sample_disable), .irq(irq)
    );

    // Clock of 4 ns period.
    always #2 pclk = ~pclk;

    // Prints the verdict and stops; a hang also ends up here.
    task automatic end_sim;
        if (bad_count == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Compares one value and reports a difference at once.
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // One APB transfer; signals are sampled before the edge's own updates.
    task automatic apb(input logic wr, input logic [7:0] addr,
        input logic [15:0] wd, output logic [31:0] rd, output logic err);
        int i;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= {16'h0000, wd};
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'b1 && i < 20);
        rd = prdata;
        err = pslverr;
        if (pready !== 1'b1) begin
            bad_count++;
            end_sim();
        end else begin
            psel <= 1'b0;
            penable <= 1'b0;
            // One idle edge keeps the next setup from colliding with release.
            @(posedge pclk);
        end
    endtask

    task automatic wr(input logic [5:0] idx, input logic [15:0] d);
        logic [31:0] rd;
        logic err;
        apb(1'b1, {idx, 2'b00}, d, rd, err);
        check({31'h0, err}, 32'h0);
    endtask

    // Reads one register and compares the whole word with no error.
    task automatic rchk(input logic [5:0] idx, input logic [15:0] exp);
        logic [31:0] rd;
        logic err;
        apb(1'b0, {idx, 2'b00}, 16'h0000, rd, err);
        check(rd, {16'h0000, exp});
        check({31'h0, err}, 32'h0);
    endtask

    // Access that must be refused with an error and zero data.
    task automatic rerr(input logic [7:0] addr);
        logic [31:0] rd;
        logic err;
        apb(1'b0, addr, 16'h0000, rd, err);
        check(rd, 32'h0);
        check({31'h0, err}, 32'h1);
    endtask

    // One conversion, then its result and raw readbacks; fin is expected.
    task automatic conv(input logic [2:0] ch, input logic [11:0] raw,
        input logic [11:0] hi, input logic [11:0] lo, input logic [11:0] fin);
        logic [5:0] ridx;
        conv_valid <= 1'b1;
        conv_channel <= ch;
        conv_raw <= raw;
        thr_high <= hi;
        thr_low <= lo;
        @(posedge pclk);
        conv_valid <= 1'b0;
        @(posedge pclk);
        flags_exp[ch + 1] = (fin > hi) || (fin < lo);
        ridx = (ch < 3'h3) ? (6'h24 + {3'h0, ch}) : 6'h27;
        rchk(ridx, {4'h0, fin});
        rchk(dabp_pkg::IDX_RAW_CONV, {4'h0, raw});
    endtask

    // Main sequence; each group exercises one behaviour of the block.
    initial begin
        tick(6);
        presetn <= 1'b1;
        @(posedge pclk);
        check({31'h0, irq}, 32'h0);
        check({31'h0, ground_sample_disable}, 32'h0);
        foreach (idx_list[k]) begin
            rchk(idx_list[k], 16'h0000);
        end
        // Unmapped and misaligned addresses are refused.
        rerr(8'h80);
        rerr(8'h8d);
        // Read-only words ignore writes.
        wr(dabp_pkg::IDX_LIMIT_FLAGS, 16'hffff);
        wr(dabp_pkg::IDX_RAW_CONV, 16'hffff);
        rchk(dabp_pkg::IDX_LIMIT_FLAGS, 16'h0000);
        rchk(dabp_pkg::IDX_RAW_CONV, 16'h0000);
        dac_code <= 16'ha5c3;
        tick(2);
        rchk(dabp_pkg::IDX_DAC_CODE, 16'ha5c3);
        // Interrupt raised, cleared by read, then masked.
        wr(dabp_pkg::IDX_EVT_MASK, 16'h0003);
        rchk(dabp_pkg::IDX_EVT_MASK, 16'h0003);
        conv(3'h0, 12'h100, 12'h0ff, 12'h000, 12'h100);
        check({31'h0, irq}, 32'h1);
        rchk(dabp_pkg::IDX_EVT_STATUS, 16'h0003);
        tick(2);
        check({31'h0, irq}, 32'h0);
        rchk(dabp_pkg::IDX_EVT_STATUS, 16'h0000);
        wr(dabp_pkg::IDX_EVT_MASK, 16'h0000);
        conv(3'h1, 12'h050, 12'hfff, 12'h000, 12'h050);
        check({31'h0, irq}, 32'h0);
        rchk(dabp_pkg::IDX_EVT_STATUS, 16'h0001);
        rchk(dabp_pkg::IDX_LIMIT_FLAGS, flags_exp);
        // Measured offset corrects results; low values clamp at zero.
        offset_valid <= 1'b1;
        offset_measured <= 12'h005;
        @(posedge pclk);
        offset_valid <= 1'b0;
        @(posedge pclk);
        rchk(dabp_pkg::IDX_CMP_OFFSET, 16'h0005);
        conv(3'h2, 12'h100, 12'hfff, 12'h000, 12'h0fb);
        conv(3'h1, 12'h003, 12'hfff, 12'h001, 12'h000);
        // Override with minus two; readback keeps the measured value.
        wr(dabp_pkg::IDX_BYPASS, 16'h4ffe);
        rchk(dabp_pkg::IDX_BYPASS, 16'h4ffe);
        conv(3'h0, 12'h100, 12'hfff, 12'h000, 12'h102);
        rchk(dabp_pkg::IDX_CMP_OFFSET, 16'h0005);
        rchk(dabp_pkg::IDX_LIMIT_FLAGS, flags_exp);
        // Substitution feeds the result and the limit check.
        wr(dabp_pkg::IDX_BYPASS, 16'ha123);
        check({31'h0, ground_sample_disable}, 32'h1);
        conv(3'h2, 12'h800, 12'h100, 12'h000, 12'h123);
        rchk(dabp_pkg::IDX_LIMIT_FLAGS, flags_exp);
        // Both enables: override wins, substitution reads back zero.
        wr(dabp_pkg::IDX_BYPASS, 16'hd010);
        rchk(dabp_pkg::IDX_BYPASS, 16'h4010);
        check({31'h0, ground_sample_disable}, 32'h0);
        conv(3'h0, 12'h100, 12'hfff, 12'h000, 12'h0f0);
        // Diagnostic mux channels, odd ones outside their limits.
        wr(dabp_pkg::IDX_BYPASS, 16'h0000);
        for (int c = 3; c < 8; c++) begin
            conv(c[2:0], 12'h230 + 12'(c), (c % 2 == 1) ? 12'h1ff : 12'hfff,
                12'h000, 12'h22b + 12'(c));
        end
        rchk(dabp_pkg::IDX_LIMIT_FLAGS, flags_exp);
        end_sim();
    end
endmodule
`default_nettype wire

/* File: src/dabp_pkg.sv */
// Shared constants for the diagnostic converter readback and bypass block.
package dabp_pkg;
    // Widths of the converter data, of each register word and of the channel code.
    localparam int ADC_W = 12;
    localparam int REG_W = 16;
    localparam int CH_W = 3;

    // Register indices; the byte address on the bus is four times the index.
    localparam logic [5:0] IDX_LIMIT_FLAGS = 6'h23;
    localparam logic [5:0] IDX_EXT0_RESULT = 6'h24;
    localparam logic [5:0] IDX_EXT1_RESULT = 6'h25;
    localparam logic [5:0] IDX_TEMP_RESULT = 6'h26;
    localparam logic [5:0] IDX_SDMUX_RESULT = 6'h27;
    localparam logic [5:0] IDX_CMP_OFFSET = 6'h28;
    localparam logic [5:0] IDX_DAC_CODE = 6'h2c;
    localparam logic [5:0] IDX_RAW_CONV = 6'h2d;
    localparam logic [5:0] IDX_BYPASS = 6'h2e;
    localparam logic [5:0] IDX_EVT_STATUS = 6'h30;
    localparam logic [5:0] IDX_EVT_MASK = 6'h31;

    // Value of every register after reset.
    localparam logic [15:0] REG_RESET = 16'h0000;

    // Field positions in the bypass register.
    localparam int BYP_SUBST_BIT = 15;
    localparam int BYP_OVERRIDE_BIT = 14;
    localparam int BYP_GND_DIS_BIT = 13;

    // Channel codes on the conversion port.
    localparam logic [2:0] CH_EXT0 = 3'h0;
    localparam logic [2:0] CH_EXT1 = 3'h1;
    localparam logic [2:0] CH_TEMP = 3'h2;
    localparam logic [2:0] CH_REFERENCE = 3'h3;
    localparam logic [2:0] CH_PAD_SUPPLY = 3'h4;
    localparam logic [2:0] CH_CORE_SUPPLY = 3'h5;
    localparam logic [2:0] CH_ZERO_TEMPCO = 3'h6;
    localparam logic [2:0] CH_OUT_VOLTAGE = 3'h7;

    // Flag bit of channel c sits at c plus this base.
    localparam int FLAG_BASE = 1;
    localparam int NUM_CH = 8;

    // Event status bits.
    localparam int EVT_CONV_DONE = 0;
    localparam int EVT_LIMIT_FAIL = 1;
    localparam int EVT_W = 2;

    // Upper end of the result range.
    localparam logic [11:0] ADC_FULL = 12'hfff;
endpackage

/* File: src/dabp_top.sv */
// Register file, limit checks and bypass control of the diagnostic converter.
// What this block does
// - One read-only limit-fail flag per channel, output voltage bit 8 down to external input 0 bit 1.
// - Separate 12-bit results for external input 0, 1, temperature and the diagnostic mux, upper bits zero.
// - The measured comparator offset is readable and corrects each conversion unless overridden or substituted.
// - Under offset override the bypass data is the offset, while the readback keeps the measured value.
// - Under offset override the bypass data is taken as a two's complement number.
// - Every raw conversion lands in a read-only register, without offset and never replaced.
// - Under result substitution the bypass data becomes the channel result and feeds the limit check.
// - With both bypass enables set, the offset override wins and substitution is forced to zero.
// - Bypass bit 13 low samples ground during conversion; high skips that ground sample.
// - A read-only register mirrors the DAC code applied to the analog circuit.
//
// The APB register port was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module dabp_top #(
    parameter int PADDR_W = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [PADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic conv_valid,
    input wire logic [2:0] conv_channel,
    input wire logic [11:0] conv_raw,
    input wire logic offset_valid,
    input wire logic [11:0] offset_measured,
    input wire logic [15:0] dac_code,
    input wire logic [11:0] thr_high,
    input wire logic [11:0] thr_low,
    output logic ground_sample_disable,
    output logic irq
);
    localparam int AW = dabp_pkg::ADC_W;

    // The index decode needs six address bits above the byte lane bits.
    if (PADDR_W < 8) begin : g_addr_w_check
        $error("dabp_top needs PADDR_W of at least 8");
    end

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_RESP = 2'b10
    } dabp_state_t;

    dabp_state_t state;
    dabp_state_t next_state;

    wire logic [15:0] limit_flags;
    logic chan_fail [dabp_pkg::NUM_CH];
    logic [11:0] ext0_result;
    logic [11:0] ext1_result;
    logic [11:0] temp_result;
    logic [11:0] sdmux_result;
    logic [11:0] cmp_offset;
    logic [15:0] dac_applied;
    logic [11:0] raw_conv;
    logic [15:0] bypass;
    logic [1:0] evt_status;
    logic [1:0] evt_mask;

    // True when an index names one of the mapped registers.
    function automatic logic dabp_mapped(input logic [5:0] idx);
        case (idx)
            dabp_pkg::IDX_LIMIT_FLAGS, dabp_pkg::IDX_EXT0_RESULT,
            dabp_pkg::IDX_EXT1_RESULT, dabp_pkg::IDX_TEMP_RESULT,
            dabp_pkg::IDX_SDMUX_RESULT, dabp_pkg::IDX_CMP_OFFSET,
            dabp_pkg::IDX_DAC_CODE, dabp_pkg::IDX_RAW_CONV,
            dabp_pkg::IDX_BYPASS, dabp_pkg::IDX_EVT_STATUS,
            dabp_pkg::IDX_EVT_MASK: dabp_mapped = 1'b1;
            default: dabp_mapped = 1'b0;
        endcase
    endfunction

    // True when a channel code belongs to the diagnostic mux.
    function automatic logic dabp_is_sd(input logic [2:0] ch);
        dabp_is_sd = (ch >= dabp_pkg::CH_REFERENCE);
    endfunction

    // Bus decode; the access completes in the cycle after it is seen.
    wire logic [5:0] idx;
    wire logic lane_ok;
    wire logic hit;
    wire logic take;
    wire logic wr_take;
    wire logic rd_take;
    assign idx = paddr[7:2];
    assign lane_ok = (paddr[1:0] == 2'b00);
    assign hit = lane_ok && dabp_mapped(idx);
    assign take = psel && penable && (state == ST_IDLE);
    // A write lands at the edge where the master samples pready high.
    assign wr_take = psel && penable && pwrite && hit && (state == ST_RESP);
    assign rd_take = take && !pwrite && hit;

    // Effective enables; override has priority over substitution.
    wire logic override_en;
    wire logic subst_en;
    assign override_en = bypass[dabp_pkg::BYP_OVERRIDE_BIT];
    assign subst_en = bypass[dabp_pkg::BYP_SUBST_BIT] && !override_en;

    // Final value of the conversion in flight.
    wire logic [11:0] final_value;
    dabp_value_path #(
        .ADC_W(AW)
    ) u_value_path (
        .raw_value(conv_raw),
        .measured_offset(cmp_offset),
        .bypass_data(bypass[11:0]),
        .offset_override_enable(override_en),
        .result_substitute_enable(subst_en),
        .final_value(final_value)
    );

    // Limit check of the finished value against its thresholds.
    wire logic out_of_range;
    assign out_of_range = (final_value > thr_high)
                          || (final_value < thr_low);

    // Stored write to the bypass register; substitution forced off if both.
    wire logic [15:0] bypass_wr;
    assign bypass_wr = {pwdata[15] & ~pwdata[14], pwdata[14:13],
                        1'b0, pwdata[11:0]};

    // Event status: set wins over clear-on-read.
    wire logic [1:0] evt_set;
    wire logic evt_clr;
    wire logic [1:0] next_evt_status;
    assign evt_set[dabp_pkg::EVT_CONV_DONE] = conv_valid;
    assign evt_set[dabp_pkg::EVT_LIMIT_FAIL] = conv_valid && out_of_range;
    assign evt_clr = rd_take && (idx == dabp_pkg::IDX_EVT_STATUS);
    assign next_evt_status = (evt_clr ? 2'b00 : evt_status) | evt_set;

    // Read multiplexer; reserved bits read as zero.
    logic [15:0] rd_word;
    always_comb begin
        case (idx)
            dabp_pkg::IDX_LIMIT_FLAGS: rd_word = limit_flags;
            dabp_pkg::IDX_EXT0_RESULT: rd_word = {4'h0, ext0_result};
            dabp_pkg::IDX_EXT1_RESULT: rd_word = {4'h0, ext1_result};
            dabp_pkg::IDX_TEMP_RESULT: rd_word = {4'h0, temp_result};
            dabp_pkg::IDX_SDMUX_RESULT: rd_word = {4'h0, sdmux_result};
            dabp_pkg::IDX_CMP_OFFSET: rd_word = {4'h0, cmp_offset};
            dabp_pkg::IDX_DAC_CODE: rd_word = dac_applied;
            dabp_pkg::IDX_RAW_CONV: rd_word = {4'h0, raw_conv};
            dabp_pkg::IDX_BYPASS: rd_word = bypass;
            dabp_pkg::IDX_EVT_STATUS: rd_word = {14'h0000, evt_status};
            dabp_pkg::IDX_EVT_MASK: rd_word = {14'h0000, evt_mask};
            default: rd_word = 16'h0000;
        endcase
    end

    // Bus state: one wait cycle, then a single response cycle.
    always_comb begin
        case (state)
            ST_IDLE: next_state = take ? ST_RESP : ST_IDLE;
            ST_RESP: next_state = ST_IDLE;
            default: next_state = ST_IDLE;
        endcase
    end

    // Bus response flops.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_IDLE;
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            state <= next_state;
            pready <= take;
            pslverr <= take && !hit;
            if (take) begin
                prdata <= (!pwrite && hit) ? {16'h0000, rd_word}
                                           : 32'h0000_0000;
            end
        end
    end

    // Writable registers; writes to read-only words are ignored.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bypass <= dabp_pkg::REG_RESET;
            evt_mask <= 2'b00;
            ground_sample_disable <= 1'b0;
        end else if (wr_take && idx == dabp_pkg::IDX_BYPASS) begin
            bypass <= bypass_wr;
            ground_sample_disable <= pwdata[dabp_pkg::BYP_GND_DIS_BIT];
        end else if (wr_take && idx == dabp_pkg::IDX_EVT_MASK) begin
            evt_mask <= pwdata[1:0];
        end
    end

    // Measured offset and DAC code tracking; bypass never touches them.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmp_offset <= 12'h000;
            dac_applied <= dabp_pkg::REG_RESET;
        end else begin
            dac_applied <= dac_code;
            if (offset_valid) begin
                cmp_offset <= offset_measured;
            end
        end
    end

    // Raw value and per-channel results, written at each finished conversion.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            raw_conv <= 12'h000;
            ext0_result <= 12'h000;
            ext1_result <= 12'h000;
            temp_result <= 12'h000;
            sdmux_result <= 12'h000;
        end else if (conv_valid) begin
            raw_conv <= conv_raw;
            if (conv_channel == dabp_pkg::CH_EXT0) begin
                ext0_result <= final_value;
            end
            if (conv_channel == dabp_pkg::CH_EXT1) begin
                ext1_result <= final_value;
            end
            if (conv_channel == dabp_pkg::CH_TEMP) begin
                temp_result <= final_value;
            end
            if (dabp_is_sd(conv_channel)) begin
                sdmux_result <= final_value;
            end
        end
    end

    // One flag per channel, reflecting that channel's latest check.
    genvar g;
    generate
        for (g = 0; g < dabp_pkg::NUM_CH; g++) begin : g_flag
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    chan_fail[g] <= 1'b0;
                end else if (conv_valid && conv_channel == 3'(g)) begin
                    chan_fail[g] <= out_of_range;
                end
            end
            assign limit_flags[g + dabp_pkg::FLAG_BASE] = chan_fail[g];
        end
    endgenerate
    assign limit_flags[0] = 1'b0;
    assign limit_flags[15:9] = 7'h00;

    // Events and the level interrupt.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            evt_status <= 2'b00;
            irq <= 1'b0;
        end else begin
            evt_status <= next_evt_status;
            irq <= |(next_evt_status & evt_mask);
        end
    end

    // Checks on the block's own behaviour.
    a_flag_from_limit: assert property (
        @(posedge pclk) disable iff (!presetn)
        conv_valid && out_of_range && conv_channel == dabp_pkg::CH_TEMP
        |=> limit_flags[3] && evt_status[dabp_pkg::EVT_LIMIT_FAIL])
        else $error("limit fail did not set the temperature flag");

    a_flags_reserved_zero: assert property (
        @(posedge pclk) disable iff (!presetn)
        pready && !pslverr && $past(idx) == dabp_pkg::IDX_LIMIT_FLAGS
        && !$past(pwrite) |-> prdata[31:9] == '0 && prdata[0] == 1'b0)
        else $error("reserved flag bits read nonzero");

    a_ext1_result_path: assert property (
        @(posedge pclk) disable iff (!presetn)
        conv_valid && conv_channel == dabp_pkg::CH_EXT1 && !subst_en
        && !override_en && cmp_offset == 12'h000
        |=> ext1_result == $past(conv_raw))
        else $error("external input 1 result not stored");

    a_offset_kept: assert property (
        @(posedge pclk) disable iff (!presetn)
        !offset_valid |=> $stable(cmp_offset))
        else $error("offset readback changed without a measurement");

    a_override_signed: assert property (
        @(posedge pclk) disable iff (!presetn)
        conv_valid && override_en && bypass[11] && !conv_raw[11]
        && conv_channel == dabp_pkg::CH_EXT0
        |=> ext0_result == $past(conv_raw) - $past(bypass[11:0]))
        else $error("override offset not taken as signed");

    a_raw_untouched: assert property (
        @(posedge pclk) disable iff (!presetn)
        conv_valid |=> raw_conv == $past(conv_raw))
        else $error("raw register differs from converter value");

    a_substitute_value: assert property (
        @(posedge pclk) disable iff (!presetn)
        conv_valid && subst_en && conv_channel == dabp_pkg::CH_TEMP
        |=> temp_result == $past(bypass[11:0]))
        else $error("substituted value missing from result");

    a_override_priority: assert property (
        @(posedge pclk) disable iff (!presetn)
        bypass[dabp_pkg::BYP_OVERRIDE_BIT]
        |-> !bypass[dabp_pkg::BYP_SUBST_BIT])
        else $error("both bypass enables stored");

    a_ground_sample: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr_take && idx == dabp_pkg::IDX_BYPASS
        |=> ground_sample_disable == $past(pwdata[13]) ##1
            $stable(ground_sample_disable) || $past(wr_take))
        else $error("ground sample control not following bit 13");

    a_dac_mirror: assert property (
        @(posedge pclk) disable iff (!presetn)
        ##1 dac_applied == $past(dac_code))
        else $error("applied code not mirrored");

    a_irq_level: assert property (
        @(posedge pclk) disable iff (!presetn)
        conv_valid && evt_mask[dabp_pkg::EVT_CONV_DONE] |=> irq [*1])
        else $error("interrupt missing after unmasked event");

    a_refused_answer: assert property (
        @(posedge pclk) disable iff (!presetn)
        take && !hit |=> pready && pslverr && prdata == 32'h0000_0000)
        else $error("refused access answered without error");

    a_one_answer: assert property (
        @(posedge pclk) disable iff (!presetn)
        take |=> pready ##1 !pready)
        else $error("bus answer not a single cycle");

    a_ground_mirror: assert property (
        @(posedge pclk) disable iff (!presetn)
        ground_sample_disable == bypass[dabp_pkg::BYP_GND_DIS_BIT])
        else $error("ground sample control differs from bypass bit");

    a_status_sticky: assert property (
        @(posedge pclk) disable iff (!presetn)
        evt_status[dabp_pkg::EVT_LIMIT_FAIL] && !evt_clr
        |=> evt_status[dabp_pkg::EVT_LIMIT_FAIL])
        else $error("limit fail status dropped without a read");
endmodule
`default_nettype wire

/* File: src/dabp_value_path.sv */
// Offset correction and substitution of one conversion value.
`timescale 1ns/1ns
`default_nettype none
module dabp_value_path #(
    parameter int ADC_W = 12
) (
    input wire logic [ADC_W-1:0] raw_value,
    input wire logic [ADC_W-1:0] measured_offset,
    input wire logic [ADC_W-1:0] bypass_data,
    input wire logic offset_override_enable,
    input wire logic result_substitute_enable,
    output logic [ADC_W-1:0] final_value
);
    localparam int EXT_W = ADC_W + 2;
    localparam logic signed [EXT_W-1:0] TOP = EXT_W'((1 << ADC_W) - 1);

    wire logic [ADC_W-1:0] use_offset;
    wire logic signed [EXT_W-1:0] raw_ext;
    wire logic signed [EXT_W-1:0] off_ext;
    wire logic signed [EXT_W-1:0] diff;
    wire logic [ADC_W-1:0] clamped;

    // Override takes priority; the bypass data is then a signed offset.
    assign use_offset = offset_override_enable ? bypass_data
                                               : measured_offset;
    assign raw_ext = $signed({2'b00, raw_value});
    assign off_ext = $signed({{2{use_offset[ADC_W-1]}}, use_offset});
    assign diff = raw_ext - off_ext;

    // Clamp so that a large offset never wraps a result round the scale.
    assign clamped = (diff < 0) ? '0 :
                     (diff > TOP) ? TOP[ADC_W-1:0] : diff[ADC_W-1:0];

    // Substitution ignores the offset entirely.
    assign final_value = (result_substitute_enable && !offset_override_enable)
                         ? bypass_data : clamped;
endmodule
`default_nettype wire
